// ===== clb_ctrl.sv
// Per-channel law, bypass and loop control with control highway slot and marker paths.
// Assumes PCM datapath on i_clk looks up channel settings via i_pcm_chan.
module clb_ctrl #(
    parameter int DLY = clb_pkg::SEND_DELAY_BITS
) (
    input  wire logic        i_clk,          // 40 MHz clock
    input  wire logic        i_reset,        // Sync reset, high
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB direction
    input  wire logic [7:0]  paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error
    input  wire logic        i_system_clock_in, // Pin: highway bit-phase clock
    input  wire logic        i_frame_sync_n,    // Pin: multiframe sync, low
    input  wire logic        i_ctrl_highway_in, // Pin: highway data in
    input  wire logic        i_send_in_bit,     // Pin: send PCM in
    input  wire logic        i_mframe_marker_in,// Pin: multiframe marker
    input  wire logic        i_robbed_bit_marker,// Pin: robbed bit marker
    input  wire logic        i_suppressor_off_pin,// Pin: suppressor off
    input  wire logic [31:0] i_serial_conv_dis, // Serial per-channel conv disable
    input  wire logic        i_tone_det,     // Modem tone pulse
    input  wire logic [4:0]  i_tone_chan,    // Modem tone channel
    input  wire logic [4:0]  i_pcm_chan,     // Channel looked up
    input  wire logic        i_send_calc_bit,// Computed send bit
    output logic             o_ctrl_highway_out, // Highway data out
    output logic             o_ctrl_highway_oe,  // Highway drive enable
    output logic             o_send_out_bit, // Send PCM out
    output logic             o_mframe_marker_out, // Delayed marker
    output logic             o_bypass,       // Channel bypass
    output logic             o_nlp_bypass,   // Suppressor bypass
    output logic             o_transcode,    // Law conversion active
    output logic             o_clear64,      // Clear channel
    output logic             o_near_alaw,    // Near end A-law
    output logic             o_far_alaw,     // Far end A-law
    output logic             o_coef_clear,   // Clear echo estimate
    output logic             o_spc_reset,    // Reset speech control
    output logic             o_send_full_bypass, // Send path unprocessed
    output logic             o_recv_full_bypass, // Receive path unprocessed
    output logic             o_full_pass,    // Whole canceller passed
    output logic             o_rs_loop,      // Receive out to send in
    output logic             o_sr_loop       // Send out to receive in
);
    // Every check here runs on i_clk and rests while reset is held
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // ****************************************
    // State
    // ****************************************
    logic [6:0]  s1, s2;
    logic        sclk_d;
    logic [1:0]  ph, next_ph;
    logic [2:0]  bt, next_bt;
    logic [4:0]  ch, next_ch;
    logic [4:0]  fr, next_fr;
    logic [12:0] g, next_g, g_act, next_g_act;
    logic [17:0] align, next_align;
    logic [4:0]  sel, next_sel;
    logic [7:0]  cfg [32], next_cfg [32], cfg_act [32], next_cfg_act [32];
    logic [7:0]  hw [32], next_hw [32];
    logic [31:0] modem, next_modem;
    logic [7:0]  rx_sr, next_rx_sr, tx_sr, next_tx_sr;
    logic [DLY-1:0] d_send, next_d_send, d_mf, next_d_mf;
    logic        robbed, next_robbed;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        next_hw_out, next_hw_oe, next_send_out, next_mf_out;
    logic [7:0]  eo, next_eo;
    logic        fall, frame_tick;
    logic [7:0]  st_ev;

    // Evaluates effective settings of one channel
    function automatic logic [7:0] eval(input logic [12:0] gg, input logic [7:0] c,
            input logic [7:0] h, input logic ser, input logic mh, input logic pin);
        logic ext, cd, dis, byp, residual_suppressor, nr, fa, fb;
        ext = ~c[clb_pkg::C_GATE] & (h[clb_pkg::H_CD] | ser);
        cd  = c[clb_pkg::C_CD] | ext;
        dis = c[clb_pkg::C_DIS] | gg[clb_pkg::G_DIS] | h[clb_pkg::H_DIS];
        byp = dis | c[clb_pkg::C_BYP] | (mh & gg[clb_pkg::G_MB]);
        residual_suppressor = byp | gg[clb_pkg::G_NLP] | pin | c[clb_pkg::C_NLP] | h[clb_pkg::H_NLP]
              | (mh & gg[clb_pkg::G_MN]);
        if (gg[clb_pkg::G_PERCH]) begin
            nr = c[clb_pkg::C_NEAR];
            fa = c[clb_pkg::C_FAR];
            fb = c[clb_pkg::C_FB];
        end else begin
            nr = gg[clb_pkg::G_NEAR];
            fa = gg[clb_pkg::G_FAR];
            fb = gg[clb_pkg::G_FB];
        end
        if (cd) begin
            nr = fb;
            fa = fb;
        end
        // Law choice ignores bypass so transcoding survives it
        return {dis, dis | (mh & gg[clb_pkg::G_MC]), fa, nr, byp & (nr == fa),
                nr != fa, residual_suppressor, byp};
    endfunction

    assign pready = 1'b1;
    // Status view uses committed settings and the synchronised suppressor pin
    assign st_ev = eval(g_act, cfg_act[sel], hw[sel], i_serial_conv_dis[sel], modem[sel],
                        s2[6]);
    assign fall = sclk_d & ~s2[0];
    assign frame_tick = fall && (next_ch == 5'h00) && (next_bt == clb_pkg::BIT_FIRST)
                        && (next_ph == clb_pkg::PHASE_LAUNCH);
    assign {o_spc_reset, o_coef_clear, o_far_alaw, o_near_alaw, o_clear64,
            o_transcode, o_nlp_bypass, o_bypass} = eo;
    assign o_send_full_bypass = g_act[clb_pkg::G_SFB];
    assign o_recv_full_bypass = g_act[clb_pkg::G_RFB];
    assign o_full_pass = g_act[clb_pkg::G_SFB] & g_act[clb_pkg::G_RFB];
    assign o_rs_loop = g_act[clb_pkg::G_RS];
    assign o_sr_loop = g_act[clb_pkg::G_SR] & ~g_act[clb_pkg::G_RS];

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_ph = ph;
        next_bt = bt;
        next_ch = ch;
        next_fr = fr;
        next_g = g;
        next_align = align;
        next_sel = sel;
        next_cfg = cfg;
        next_hw = hw;
        next_modem = modem;
        next_rx_sr = rx_sr;
        next_tx_sr = tx_sr;
        next_d_send = d_send;
        next_d_mf = d_mf;
        next_robbed = robbed;
        next_hw_out = o_ctrl_highway_out;
        next_hw_oe = o_ctrl_highway_oe;
        next_send_out = o_send_out_bit;
        next_mf_out = o_mframe_marker_out;
        next_prdata = prdata;
        next_pslverr = pslverr;
        // Bit-phase counters advance on each falling pin clock edge unless sync reloads them
        if (fall) begin
            if (!s2[1]) begin
                next_ph = align[17:16];
                next_bt = clb_pkg::BIT_FIRST;
                next_ch = align[4:0];
                next_fr = align[12:8];
                // Drive stops on a reload; the launch below restarts it in the slot
                next_hw_oe = 1'b0;
            end else begin
                next_ph = ph + 2'h1;
                if (ph == 2'h3) begin
                    next_bt = bt - 3'h1;
                    if (bt == 3'h0) begin
                        next_ch = ch + 5'h01;
                        if (ch == 5'h1F) begin
                            next_fr = fr + 5'h01;
                        end
                    end
                end
            end
            if (next_ph == clb_pkg::PHASE_SAMPLE) begin
                next_d_send = {d_send[DLY-2:0], s2[3]};
                next_d_mf = {d_mf[DLY-2:0], s2[4]};
                next_robbed = s2[5];
                if (next_ch == 5'h00) begin
                    next_rx_sr = {rx_sr[6:0], s2[2]};
                    if (next_bt == 3'h0) begin
                        next_hw[next_fr] = {rx_sr[6:0], s2[2]};
                    end
                end
            end
            if (next_ph == clb_pkg::PHASE_LAUNCH) begin
                // Robbed bit keeps the line's own send input value
                next_send_out = robbed ? d_send[DLY-1] : i_send_calc_bit;
                next_mf_out = d_mf[DLY-1];
                next_hw_oe = (next_ch == 5'h00);
                if (next_ch == 5'h00) begin
                    if (next_bt == clb_pkg::BIT_FIRST) begin
                        next_tx_sr = eval(g_act, cfg_act[next_fr], hw[next_fr],
                                          i_serial_conv_dis[next_fr], modem[next_fr],
                                          s2[6]);
                    end else begin
                        next_tx_sr = {tx_sr[6:0], 1'b0};
                    end
                    next_hw_out = next_tx_sr[7];
                end else begin
                    next_hw_out = 1'b0;
                end
            end
        end
        // Register access
        if (psel && !penable) begin
            next_pslverr = 1'b0;
            next_prdata = 32'h0000_0000;
            if (paddr == clb_pkg::ADDR_GLOBAL) begin
                next_prdata[12:0] = g;
            end else if (paddr == clb_pkg::ADDR_ALIGN) begin
                next_prdata[17:0] = align;
            end else if (paddr == clb_pkg::ADDR_CHSEL) begin
                next_prdata[4:0] = sel;
            end else if (paddr == clb_pkg::ADDR_CHCTRL) begin
                next_prdata[7:0] = cfg[sel];
            end else if (paddr == clb_pkg::ADDR_STATUS) begin
                next_prdata[7:0] = {3'h0, modem[sel], st_ev[3:0]};
                next_prdata[12:8] = fr;
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (psel && penable && pwrite) begin
            if (paddr == clb_pkg::ADDR_GLOBAL) begin
                next_g = pwdata[12:0];
            end else if (paddr == clb_pkg::ADDR_ALIGN) begin
                next_align = pwdata[17:0];
            end else if (paddr == clb_pkg::ADDR_CHSEL) begin
                next_sel = pwdata[4:0];
            end else if (paddr == clb_pkg::ADDR_CHCTRL) begin
                next_cfg[sel] = pwdata[7:0];
            end else if (paddr == clb_pkg::ADDR_STATUS && pwdata[clb_pkg::ST_MODEM]) begin
                next_modem[sel] = 1'b0;
            end
        end
        // Tone detection after the clear so that a fresh event wins
        if (i_tone_det) begin
            next_modem[i_tone_chan] = 1'b1;
        end
    end

    // Settings reach the datapath only at frame boundaries
    always_comb begin
        next_g_act = g_act;
        next_cfg_act = cfg_act;
        if (frame_tick) begin
            next_g_act = g;
            next_cfg_act = cfg;
        end
        next_eo = eval(g_act, cfg_act[i_pcm_chan], hw[i_pcm_chan],
                       i_serial_conv_dis[i_pcm_chan], modem[i_pcm_chan],
                       s2[6]);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        // Pins pass two flops before use
        s1 <= {i_suppressor_off_pin, i_robbed_bit_marker, i_mframe_marker_in, i_send_in_bit,
               i_ctrl_highway_in, i_frame_sync_n, i_system_clock_in};
        s2 <= s1;
        sclk_d <= s2[0];
        if (i_reset) begin
            ph <= 2'h0;
            bt <= clb_pkg::BIT_FIRST;
            ch <= 5'h00;
            fr <= 5'h00;
            g <= clb_pkg::GLOBAL_RST;
            g_act <= clb_pkg::GLOBAL_RST;
            align <= 18'h00000;
            sel <= 5'h00;
            cfg <= '{default: clb_pkg::CHAN_RST};
            cfg_act <= '{default: clb_pkg::CHAN_RST};
            hw <= '{default: 8'h00};
            modem <= 32'h0000_0000;
            rx_sr <= 8'h00;
            tx_sr <= 8'h00;
            d_send <= '0;
            d_mf <= '0;
            robbed <= 1'b0;
            o_ctrl_highway_out <= 1'b0;
            o_ctrl_highway_oe <= 1'b0;
            o_send_out_bit <= 1'b0;
            o_mframe_marker_out <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            eo <= 8'h00;
        end else begin
            ph <= next_ph;
            bt <= next_bt;
            ch <= next_ch;
            fr <= next_fr;
            g <= next_g;
            g_act <= next_g_act;
            align <= next_align;
            sel <= next_sel;
            cfg <= next_cfg;
            cfg_act <= next_cfg_act;
            hw <= next_hw;
            modem <= next_modem;
            rx_sr <= next_rx_sr;
            tx_sr <= next_tx_sr;
            d_send <= next_d_send;
            d_mf <= next_d_mf;
            robbed <= next_robbed;
            o_ctrl_highway_out <= next_hw_out;
            o_ctrl_highway_oe <= next_hw_oe;
            o_send_out_bit <= next_send_out;
            o_mframe_marker_out <= next_mf_out;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            eo <= next_eo;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_loop_excl;
        o_rs_loop |-> !o_sr_loop;
    endproperty
    a_loop_excl: assert property (p_loop_excl) else $error("both loops active");
    property p_byp_nlp;
        o_bypass |-> o_nlp_bypass;
    endproperty
    a_byp_nlp: assert property (p_byp_nlp) else $error("bypass without suppressor");
    property p_clear64;
        o_clear64 |-> o_bypass && (o_near_alaw == o_far_alaw);
    endproperty
    a_clear64: assert property (p_clear64) else $error("bad clear channel");
    property p_xcode;
        (o_bypass && (o_near_alaw != o_far_alaw)) |-> o_transcode;
    endproperty
    a_xcode: assert property (p_xcode) else $error("transcode lost in bypass");
    property p_dis;
        o_spc_reset |-> o_coef_clear && o_bypass;
    endproperty
    a_dis: assert property (p_dis) else $error("disable effects missing");
    property p_oe_slot;
        o_ctrl_highway_oe |-> ch == 5'h00;
    endproperty
    a_oe_slot: assert property (p_oe_slot) else $error("drive outside slot");
    property p_oe_launch;
        $rose(o_ctrl_highway_oe) |-> ph == clb_pkg::PHASE_LAUNCH;
    endproperty
    a_oe_launch: assert property (p_oe_launch) else $error("drive off phase");
    property p_commit;
        !frame_tick |=> $stable(g_act);
    endproperty
    a_commit: assert property (p_commit) else $error("settings changed mid frame");
    property p_sync;
        (fall && !s2[1]) |=> (ph == align[17:16]) && (ch == align[4:0]);
    endproperty
    a_sync: assert property (p_sync) else $error("sync load wrong");
endmodule : clb_ctrl

// ===== clb_pkg.sv
// Constants, register map and field layout for the channel law/bypass control block.
// Assumes an APB master on i_clk and a control highway bit clock far slower than i_clk.
// Functional notes
// - Global mode: all channels use global laws
// - Global law bit one is A-law
// - Conversion-disabled channel uses global fallback law in global mode
// - External conversion-disable sources blocked when gate bit set
// - Per-channel mode uses own laws and fallback
// - Suppressor-off by pin or bit bypasses suppressor
// - Bypass skips attenuators, subtractor and suppressor
// - Disable gives bypass, coefficient clear, speech reset
// - Transcoding stays active when bypassed or disabled
// - Modem tone triggers configurable action set
// - Bypass with equal laws gives clear channel
// - Both full-bypass bits pass canceller unprocessed
// - Receive-to-send loop feeds receive out back
// - Send-to-receive loop feeds send out back
// - Both loops set: only receive-to-send acts
// - Highway: 32 channels, 32 frames, sync aligned
// - Drive and read only channel zero slot
// - Control frame n serves PCM channel n
// - Offsets relocate the slot anywhere
// - Highway output in phase with input
// - Marker delay equals send path delay
// - Robbed-bit marker passes send input bit
// - Sample at phase two, launch at phase zero
package clb_pkg;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_GLOBAL = 8'h00;
    localparam logic [7:0] ADDR_ALIGN  = 8'h04;
    localparam logic [7:0] ADDR_CHSEL  = 8'h08;
    localparam logic [7:0] ADDR_CHCTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // ****************************************
    // Global register fields
    // ****************************************
    localparam int G_PERCH = 0, G_FAR = 1, G_NEAR = 2, G_FB = 3, G_NLP = 4;
    localparam int G_DIS = 5, G_SFB = 6, G_RFB = 7, G_RS = 8, G_SR = 9;
    localparam int G_MB = 10, G_MN = 11, G_MC = 12, G_W = 13;
    // ****************************************
    // Channel word fields
    // ****************************************
    localparam int C_CD = 0, C_FB = 1, C_GATE = 2, C_NEAR = 3, C_FAR = 4;
    localparam int C_DIS = 5, C_NLP = 6, C_BYP = 7, C_W = 8;
    // Highway control byte fields
    localparam int H_DIS = 0, H_NLP = 1, H_CD = 2;
    localparam int ST_MODEM = 4;
    // ****************************************
    // Reset values and highway geometry
    // ****************************************
    localparam logic [12:0] GLOBAL_RST = 13'h0000;
    localparam logic [7:0]  CHAN_RST   = 8'h00;
    localparam logic [1:0]  PHASE_SAMPLE = 2'h2;
    localparam logic [1:0]  PHASE_LAUNCH = 2'h0;
    localparam logic [2:0]  BIT_FIRST    = 3'h7;
    localparam int          SEND_DELAY_BITS = 256;
endpackage : clb_pkg

// ===== clb_far_model.sv
// Far side model: system clock, multiframe sync, control highway and send stream.
// Assumes the block samples these pins with its own faster clock.
module clb_far_model (
    input  wire logic       i_hw_out,   // Highway data from block
    input  wire logic       i_hw_oe,    // Highway drive enable
    input  wire logic       i_send_out, // Send PCM out
    input  wire logic       i_mark_out, // Delayed marker
    output logic            o_sclk,     // Bit-phase clock
    output logic            o_sync_n,   // Multiframe sync, low
    output logic            o_hw_in,    // Highway data to block
    output logic            o_send_in,  // Send PCM in
    output logic            o_mark_in,  // Multiframe marker
    output logic            o_robbed,   // Robbed bit marker
    output int              o_bad,      // Drive enable faults
    output int              o_diff,     // Send out wrong (marker if robbed, else 1)
    output int              o_ones,     // Marker ones seen
    output logic [7:0]      o_tx [8]    // Byte caught per frame
);
    timeunit 1ns;
    timeprecision 100ps;
    int   nf, ph, bn, ch, fr, bc;
    logic on, rb;
    // Byte sent in the slot of frame f; later frames carry no requests
    function automatic logic slot(input int f, input int b);
        logic [7:0] v;
        v = (f == 0) ? 8'h02 : ((f == 1) ? 8'h01 : 8'h00);
        return v[b];
    endfunction
    // Free running clock, phase unrelated to the block clock
    initial begin
        {o_sclk, o_sync_n, o_hw_in, o_send_in, o_mark_in, on} = 6'h10;
        {nf, bc, o_bad, o_diff, o_ones} = {5{32'h0}};
        o_robbed = 1'h1;
        o_tx = '{default: 8'h00};
        #37;
        forever #100 o_sclk = ~o_sclk;
    end
    // One sync pulse spanning falling edge 21
    always @(posedge o_sclk) o_sync_n <= (nf != 20);
    // Counters restart at the sync edge; launch at phase 0, sample at phase 2
    always @(negedge o_sclk) begin
        nf++;
        if (!o_sync_n) begin
            {ph, bn, ch, fr} = {32'h0, 32'h7, 32'h0, 32'h0};
            on = 1'h1;
        end else if (on) begin
            ph = (ph + 1) % 4;
            if (ph == 0) bn = (bn + 7) % 8;
            if (ph == 0 && bn == 7) ch = (ch + 1) % 32;
            if (ph == 0 && bn == 7 && ch == 0) fr++;
        end
        if (on && ph == 0) begin
            bc++;
            // Slots of other devices: nobody drives, so the line keeps moving
            o_hw_in = (ch == 0) ? slot(fr, bn) : ~o_hw_in;
            o_send_in = bc[0] ^ bc[3];
            o_mark_in = o_send_in;
            // Robbed flag of the bit just ended governs the next output bit
            rb = o_robbed;
            o_robbed = bc[2];
        end
        if (on && ph == 2) begin
            if (i_hw_oe !== (ch == 0) && (fr > 0 || ch != 0)) o_bad++;
            if (ch == 0 && fr < 8) o_tx[fr][bn] = i_hw_out;
            // Unrobbed bits carry the computed bit, which the bench holds high
            if (i_send_out !== (rb ? i_mark_out : 1'b1)) o_diff++;
            if (i_mark_out === 1'b1) o_ones++;
        end
    end
endmodule // clb_far_model

// ===== clb_ctrl_tb.sv
// Self-checking bench for clb_ctrl: APB set-up, lookups, highway and send paths.
// Assumes clb_pkg and clb_far_model are compiled first.
module clb_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [1:0] g; logic [4:0] ch; logic [7:0] c; logic [7:0] ex;}
        clb_row_type;
    localparam clb_row_type ROWS [20] = '{
        '{2'h0, 5'h02, 8'h00, 8'h24}, '{2'h0, 5'h03, 8'h18, 8'h24},
        '{2'h0, 5'h04, 8'h01, 8'h30}, '{2'h0, 5'h05, 8'h80, 8'h27},
        '{2'h0, 5'h06, 8'h20, 8'hE7}, '{2'h0, 5'h07, 8'h40, 8'h26},
        '{2'h0, 5'h08, 8'h00, 8'h30}, '{2'h0, 5'h09, 8'h04, 8'h24},
        '{2'h1, 5'h00, 8'h00, 8'h02}, '{2'h1, 5'h01, 8'h00, 8'hCB},
        '{2'h1, 5'h02, 8'h08, 8'h14}, '{2'h1, 5'h03, 8'h10, 8'h24},
        '{2'h1, 5'h04, 8'h18, 8'h30}, '{2'h1, 5'h05, 8'h0B, 8'h30},
        '{2'h1, 5'h06, 8'h88, 8'h17}, '{2'h1, 5'h07, 8'h98, 8'h3B},
        '{2'h1, 5'h08, 8'h80, 8'h0B}, '{2'h1, 5'h09, 8'h05, 8'h00},
        '{2'h2, 5'h03, 8'h10, 8'hE7}, '{2'h2, 5'h04, 8'h18, 8'hFB}};
    localparam logic [31:0] GW [3] = '{32'h0000020A, 32'h00001947, 32'h000003E1};
    localparam logic [4:0]  GX [3] = '{5'h01, 5'h0A, 5'h1E};
    logic        i_clk, i_reset, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, lk, tx [8];
    logic [31:0] pwdata, prdata, rd, i_serial_conv_dis;
    logic        i_system_clock_in, i_frame_sync_n, i_ctrl_highway_in, i_send_in_bit;
    logic        i_mframe_marker_in, i_robbed_bit_marker, i_suppressor_off_pin, i_tone_det;
    logic [4:0]  i_tone_chan, i_pcm_chan;
    logic        i_send_calc_bit, o_ctrl_highway_out, o_ctrl_highway_oe, o_send_out_bit;
    logic        o_mframe_marker_out, o_bypass, o_nlp_bypass, o_transcode, o_clear64;
    logic        o_near_alaw, o_far_alaw, o_coef_clear, o_spc_reset, o_send_full_bypass;
    logic        o_recv_full_bypass, o_full_pass, o_rs_loop, o_sr_loop;
    int          n_errors, compares, bad, diff, ones;
    // Short delay line keeps the send path test inside a few frames
    clb_ctrl #(.DLY(8)) uut (.i_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .i_system_clock_in, .i_frame_sync_n, .i_ctrl_highway_in,
        .i_send_in_bit, .i_mframe_marker_in, .i_robbed_bit_marker, .i_suppressor_off_pin,
        .i_serial_conv_dis, .i_tone_det, .i_tone_chan, .i_pcm_chan, .i_send_calc_bit,
        .o_ctrl_highway_out, .o_ctrl_highway_oe, .o_send_out_bit, .o_mframe_marker_out,
        .o_bypass, .o_nlp_bypass, .o_transcode, .o_clear64, .o_near_alaw, .o_far_alaw,
        .o_coef_clear, .o_spc_reset, .o_send_full_bypass, .o_recv_full_bypass, .o_full_pass,
        .o_rs_loop, .o_sr_loop);
    clb_far_model far (.i_hw_out(o_ctrl_highway_out), .i_hw_oe(o_ctrl_highway_oe),
        .i_send_out(o_send_out_bit), .i_mark_out(o_mframe_marker_out),
        .o_sclk(i_system_clock_in), .o_sync_n(i_frame_sync_n), .o_hw_in(i_ctrl_highway_in),
        .o_send_in(i_send_in_bit), .o_mark_in(i_mframe_marker_in),
        .o_robbed(i_robbed_bit_marker), .o_bad(bad), .o_diff(diff), .o_ones(ones), .o_tx(tx));
    // ********************
    // Shared tasks
    // ********************
    initial i_clk = 1'h0;
    always #12.5 i_clk = ~i_clk;
    task chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // APB cycle, entered just after a rising edge; only the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge i_clk);
        penable <= 1'h1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge i_clk);
    endtask
    // Lookup shows a cycle later; a pin change needs two more for its synchroniser
    task look(input logic [4:0] c);
        i_pcm_chan <= c;
        repeat (3) @(posedge i_clk);
        #1;
        lk = {o_spc_reset, o_coef_clear, o_far_alaw, o_near_alaw, o_clear64, o_transcode,
              o_nlp_bypass, o_bypass};
        @(posedge i_clk);
    endtask
    // Frame counter moves when staged settings are committed
    task wait_commit;
        logic [4:0] f0;
        int         n;
        apb(1'h0, clb_pkg::ADDR_STATUS, 32'h0);
        f0 = rd[12:8];
        n = 0;
        do begin
            apb(1'h0, clb_pkg::ADDR_STATUS, 32'h0);
            n++;
        end while (rd[12:8] === f0 && n < 5000);
        if (n >= 5000) n_errors++;
        repeat (4) @(posedge i_clk);
    endtask
    function automatic logic [4:0] gvec();
        return {o_full_pass, o_send_full_bypass, o_recv_full_bypass, o_rs_loop, o_sr_loop};
    endfunction
    // Hang guard: whole run is about 1.03 ms
    initial begin
        #2000000;
        n_errors++;
        stop_test();
    end
    // ********************
    // Main sequence
    // ********************
    initial begin
        {i_reset, psel, penable, pwrite, paddr, pwdata} = {1'h1, 43'h0};
        {i_suppressor_off_pin, i_tone_det, i_tone_chan, i_pcm_chan} = 12'h000;
        i_send_calc_bit = 1'h1;
        i_serial_conv_dis = 32'h00000300;
        {n_errors, compares} = {32'h0, 32'h0};
        repeat (5) @(posedge i_clk);
        i_reset <= 1'h0;
        repeat (3) @(posedge i_clk);
        apb(1'h0, clb_pkg::ADDR_GLOBAL, 32'h0);
        chk({er, rd}, 33'h000000000);
        apb(1'h1, 8'h20, 32'hFFFFFFFF);
        chk({er, rd}, 33'h100000000);
        $display("reset and unmapped test done");
        for (int g = 0; g < 3; g++) begin
            apb(1'h1, clb_pkg::ADDR_GLOBAL, GW[g]);
            chk(gvec(), (g > 0) ? GX[g-1] : 5'h00);
            foreach (ROWS[i]) if (ROWS[i].g == g) begin
                apb(1'h1, clb_pkg::ADDR_CHSEL, {27'h0, ROWS[i].ch});
                apb(1'h1, clb_pkg::ADDR_CHCTRL, {24'h0, ROWS[i].c});
            end
            wait_commit();
            chk(gvec(), GX[g]);
            foreach (ROWS[i]) if (ROWS[i].g == g) begin
                look(ROWS[i].ch);
                chk(lk, ROWS[i].ex);
            end
            if (g == 1) begin
                i_suppressor_off_pin <= 1'h1;
                look(5'h02);
                chk(lk, 8'h16);
                {i_suppressor_off_pin, i_tone_chan, i_tone_det} <= 7'h07;
                @(posedge i_clk);
                i_tone_det <= 1'h0;
                look(5'h03);
                chk(lk[1:0], 2'h2);
                apb(1'h1, clb_pkg::ADDR_CHSEL, 32'h3);
                apb(1'h0, clb_pkg::ADDR_STATUS, 32'h0);
                chk(rd[4:0], 5'h16);
                apb(1'h1, clb_pkg::ADDR_STATUS, 32'h10);
                apb(1'h0, clb_pkg::ADDR_STATUS, 32'h0);
                chk(rd[4:0], 5'h04);
            end
            $display("settings group %0d test done", g);
        end
        wait_commit();
        wait_commit();
        chk(tx[4], 8'hFB);
        chk(bad, 0);
        chk(diff, 0);
        chk(ones > 0, 1'h1);
        $display("highway and send path test done");
        stop_test();
    end
endmodule // clb_ctrl_tb
